// ==== design/emic_pkg.sv ====
// package: register map, field layout and timing for the external memory port controller
package emic_pkg;
    // register offsets (byte addresses of the cpu register space)
    localparam logic [15:0] PAGE1_MAP_ADDR      = 16'hC018;
    localparam logic [15:0] PAGE2_MAP_ADDR      = 16'hC01A;
    localparam logic [15:0] UPPER_ADDR_EN_ADDR  = 16'hC038;
    localparam logic [15:0] BUS_TIMING_ADDR     = 16'hC03A;
    // reset values
    localparam logic [15:0] PAGE_MAP_RESET      = 16'h0000;
    localparam logic [15:0] BUS_TIMING_RESET    = 16'h0000;
    // upper address enable field
    localparam int          UPPER_EN_BIT        = 3;
    // bus timing control fields
    localparam int          RAM_MERGE_BIT       = 13;
    localparam int          ROM_MERGE_BIT       = 12;
    localparam int          XMEM_WIDTH_BIT      = 11;
    localparam int          XMEM_WAIT_LSB       = 8;
    localparam int          ROM_WIDTH_BIT       = 7;
    localparam int          ROM_WAIT_LSB        = 4;
    localparam int          RAM_WIDTH_BIT       = 3;
    localparam int          RAM_WAIT_LSB        = 0;
    localparam int          WAIT_W              = 3;
    localparam logic [15:0] BUS_TIMING_MASK     = 16'h3FFF;
    localparam logic [15:0] UPPER_EN_MASK       = 16'h0008;
    // page windows seen by the cpu
    localparam logic [2:0]  PAGE1_WIN_TOP       = 3'h4;   // 0x8000-0x9FFF
    localparam logic [2:0]  PAGE2_WIN_TOP       = 3'h5;   // 0xA000-0xBFFF
    localparam int          PAGE_LSB            = 13;
    localparam int          PAGE_PINS_FULL      = 9;      // pins [8:0] carry page [21:13]
    localparam int          PAGE_PINS_SRAM      = 5;      // pins [4:0] carry page [17:13]
    localparam int          PAGE_EXT_BIT        = 8;      // page address bit 21
    // upper address lines
    localparam logic [3:0]  UPPER_IDLE          = 4'hF;
    // wait states count in processor clock cycles
    localparam int          CPU_CLK_HZ          = 48_000_000;
    localparam int          SYS_CLK_HZ          = 50_000_000;
    // one processor cycle in system cycles, rounded up, never below one
    localparam int          WAIT_UNIT_CYC       = (SYS_CLK_HZ + CPU_CLK_HZ - 1) / CPU_CLK_HZ;
    // address spaces
    typedef enum logic [1:0] {
        SPACE_XMEM,
        SPACE_RAM,
        SPACE_ROM
    } emic_space_t;
endpackage

// ==== design/emic_ctrl.sv ====
// external memory port controller: page maps, upper address enable, widths, waits, selects
// Overview of operation
// - page map register contents are appended as high address bits in its window
// - cpu window 0x8000-0x9FFF drives pins [8:0] from page bits [21:13]
// - in sram mode only pins [4:0] carry page bits [17:13]
// - extended-memory select goes low for page-mapped external accesses
// - upper enable bit 3 drives A[18:15] low instead of high; resets disabled
// - from power up A[18:15] are driven high
// - wait states are counted in 48 MHz processor cycles
// - ram merge bit 13 asserts ram select with extended select
// - rom merge bit 12 asserts rom select with extended select
// - bit 11 picks extended space width, 1 is 8-bit
// - bits [10:8] give extended space wait states 0 to 7
// - bit 7 picks rom width, 1 is 8-bit
// - bits [6:4] give rom wait states 0 to 7
// - bit 3 picks ram width, 1 is 8-bit
// - bits [2:0] give ram wait states 0 to 7
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module emic_ctrl #(
    parameter int ADDR_W = 19                          // external address pins
) (
    input  wire logic              i_clk_sys,          // system clock
    input  wire logic              i_rst_n,            // async reset, active low
    input  wire logic              i_sram_mode,        // page uses sram pin subset
    // register port
    input  wire logic [15:0]       i_reg_addr,         // register byte address
    input  wire logic [15:0]       i_reg_wdata,        // register write data
    input  wire logic              i_reg_wr,           // register write strobe
    input  wire logic              i_reg_rd,           // register read strobe
    output logic      [15:0]       o_reg_rdata,        // read data, cycle after strobe
    // cpu memory request
    input  wire logic              i_cpu_req,          // access request pulse
    input  wire logic              i_cpu_we,           // 1 write, 0 read
    input  wire logic [1:0]        i_cpu_space,        // emic_space_t of target
    input  wire logic [15:0]       i_cpu_addr,         // cpu byte address
    input  wire logic [15:0]       i_cpu_wdata,        // cpu write data
    output logic                   o_cpu_stall,        // cpu must wait
    output logic                   o_cpu_done,         // access finished pulse
    output logic      [15:0]       o_cpu_rdata,        // captured read data
    // external memory pins
    output logic      [ADDR_W-1:0] o_ext_addr,         // external address
    output logic      [15:0]       o_ext_dout,         // data out
    output logic                   o_ext_doe,          // data out enable
    input  wire logic [15:0]       i_ext_din,          // data in
    output logic                   o_ext_we_n,         // write strobe
    output logic                   o_ext_oe_n,         // output enable
    output logic                   o_extended_space_select_n, // extended select
    output logic                   o_external_ram_select_n,   // ram select
    output logic                   o_external_rom_select_n    // rom select
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_DONE
    } emic_state_t;

    // registers
    logic [15:0] page1_high_address_map, next_page1;
    logic [15:0] page2_high_address_map, next_page2;
    logic        upper_address_lines_enable, next_upper;
    logic [15:0] external_bus_timing_control, next_timing;
    logic [15:0] next_reg_rdata;

    // access engine
    emic_state_t state, next_state;
    logic [2:0]  wait_left, next_wait_left;
    logic [7:0]  unit_cnt, next_unit_cnt;
    logic        second_byte, next_second_byte;
    logic        is_write, next_is_write;
    logic [1:0]  space, next_space;
    logic [15:0] addr, next_addr;
    logic [15:0] wdata, next_wdata;
    logic [15:0] rdata, next_rdata;
    logic        done, next_done;
    logic        stall, next_stall;
    logic [ADDR_W-1:0] ext_addr, next_ext_addr;
    logic        xsel_n, rsel_n, osel_n, next_xsel_n, next_rsel_n, next_osel_n;
    logic        we_n, oe_n, doe, next_we_n, next_oe_n, next_doe;
    logic [15:0] dout, next_dout;

    // field decode per space
    function automatic logic [2:0] wait_of(input logic [15:0] t, input logic [1:0] s);
        if (s == emic_pkg::SPACE_XMEM)
            wait_of = t[emic_pkg::XMEM_WAIT_LSB +: emic_pkg::WAIT_W];
        else if (s == emic_pkg::SPACE_ROM)
            wait_of = t[emic_pkg::ROM_WAIT_LSB +: emic_pkg::WAIT_W];
        else
            wait_of = t[emic_pkg::RAM_WAIT_LSB +: emic_pkg::WAIT_W];
    endfunction

    function automatic logic narrow_of(input logic [15:0] t, input logic [1:0] s);
        if (s == emic_pkg::SPACE_XMEM)
            narrow_of = t[emic_pkg::XMEM_WIDTH_BIT];
        else if (s == emic_pkg::SPACE_ROM)
            narrow_of = t[emic_pkg::ROM_WIDTH_BIT];
        else
            narrow_of = t[emic_pkg::RAM_WIDTH_BIT];
    endfunction

    // external address for one phase
    function automatic logic [ADDR_W-1:0] ext_addr_of(
        input logic [15:0] a, input logic [1:0] s, input logic hi_byte, input logic narrow,
        input logic [15:0] p1, input logic [15:0] p2, input logic up_en, input logic sram);
        logic [15:0]       pg;
        logic [ADDR_W-1:0] r;
        pg = (a[15:13] == emic_pkg::PAGE1_WIN_TOP) ? p1 : p2;
        r  = '0;
        // word addressed for 16-bit, byte addressed for 8-bit
        r[14:0] = narrow ? {a[14:1], hi_byte} : a[15:1];
        if (s == emic_pkg::SPACE_XMEM) begin
            if (sram)
                r[emic_pkg::PAGE_PINS_SRAM-1:0] =
                    pg[emic_pkg::PAGE_PINS_SRAM-1:0];
            else
                r[emic_pkg::PAGE_PINS_FULL-1:0] =
                    pg[emic_pkg::PAGE_PINS_FULL-1:0];
        end
        // upper lines driven high until software enables them
        if (up_en)
            r[ADDR_W-1:15] = '0;
        else
            r[ADDR_W-1:15] = emic_pkg::UPPER_IDLE;
        ext_addr_of = r;
    endfunction

    // register write and read decode
    always_comb begin
        next_page1     = page1_high_address_map;
        next_page2     = page2_high_address_map;
        next_upper     = upper_address_lines_enable;
        next_timing    = external_bus_timing_control;
        next_reg_rdata = 16'h0000;
        if (i_reg_wr) begin
            if (i_reg_addr == emic_pkg::PAGE1_MAP_ADDR) begin
                next_page1 = i_reg_wdata;
            end else if (i_reg_addr == emic_pkg::PAGE2_MAP_ADDR) begin
                next_page2 = i_reg_wdata;
            end else if (i_reg_addr == emic_pkg::UPPER_ADDR_EN_ADDR) begin
                next_upper = i_reg_wdata[emic_pkg::UPPER_EN_BIT];
            end else if (i_reg_addr == emic_pkg::BUS_TIMING_ADDR) begin
                next_timing = i_reg_wdata & emic_pkg::BUS_TIMING_MASK;
            end
        end
        if (i_reg_rd) begin
            if (i_reg_addr == emic_pkg::PAGE1_MAP_ADDR) begin
                next_reg_rdata = page1_high_address_map;
            end else if (i_reg_addr == emic_pkg::PAGE2_MAP_ADDR) begin
                next_reg_rdata = page2_high_address_map;
            end else if (i_reg_addr == emic_pkg::UPPER_ADDR_EN_ADDR) begin
                next_reg_rdata = upper_address_lines_enable ? emic_pkg::UPPER_EN_MASK
                                                            : 16'h0000;
            end else if (i_reg_addr == emic_pkg::BUS_TIMING_ADDR) begin
                next_reg_rdata = external_bus_timing_control;
            end
        end
    end

    // register storage
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page1_high_address_map      <= emic_pkg::PAGE_MAP_RESET;
            page2_high_address_map      <= emic_pkg::PAGE_MAP_RESET;
            upper_address_lines_enable  <= 1'b0;
            external_bus_timing_control <= emic_pkg::BUS_TIMING_RESET;
            o_reg_rdata                 <= 16'h0000;
        end else begin
            page1_high_address_map      <= next_page1;
            page2_high_address_map      <= next_page2;
            upper_address_lines_enable  <= next_upper;
            external_bus_timing_control <= next_timing;
            o_reg_rdata                 <= next_reg_rdata;
        end
    end

    // access sequencer with wait states and byte split
    always_comb begin
        logic narrow;
        logic xsel;
        narrow           = narrow_of(external_bus_timing_control, space);
        xsel             = 1'b0;
        next_state       = state;
        next_wait_left   = wait_left;
        next_unit_cnt    = unit_cnt;
        next_second_byte = second_byte;
        next_is_write    = is_write;
        next_space       = space;
        next_addr        = addr;
        next_wdata       = wdata;
        next_rdata       = rdata;
        next_done        = 1'b0;
        next_ext_addr    = ext_addr_of(addr, space, second_byte, narrow,
                                       page1_high_address_map, page2_high_address_map,
                                       upper_address_lines_enable, i_sram_mode);
        next_xsel_n      = 1'b1;
        next_rsel_n      = 1'b1;
        next_osel_n      = 1'b1;
        next_we_n        = 1'b1;
        next_oe_n        = 1'b1;
        next_doe         = 1'b0;
        next_dout        = dout;
        case (state)
            ST_IDLE: begin
                if (i_cpu_req) begin
                    next_state       = ST_WAIT;
                    next_is_write    = i_cpu_we;
                    next_space       = i_cpu_space;
                    next_addr        = i_cpu_addr;
                    next_wdata       = i_cpu_wdata;
                    next_second_byte = 1'b0;
                    next_wait_left   = wait_of(external_bus_timing_control, i_cpu_space);
                    next_unit_cnt    = 8'(emic_pkg::WAIT_UNIT_CYC - 1);
                    next_ext_addr    = ext_addr_of(i_cpu_addr, i_cpu_space, 1'b0,
                                           narrow_of(external_bus_timing_control, i_cpu_space),
                                           page1_high_address_map, page2_high_address_map,
                                           upper_address_lines_enable, i_sram_mode);
                    next_doe         = i_cpu_we;
                    next_dout        = i_cpu_wdata;
                end
            end
            ST_WAIT: begin
                next_doe  = is_write;
                next_dout = (narrow && second_byte) ? {8'h00, wdata[15:8]} : wdata;
                // count one processor cycle per wait state
                if (unit_cnt != 8'h00) begin
                    next_unit_cnt = unit_cnt - 8'h01;
                end else if (wait_left != 3'h0) begin
                    next_wait_left = wait_left - 3'h1;
                    next_unit_cnt  = 8'(emic_pkg::WAIT_UNIT_CYC - 1);
                end else begin
                    // capture the data, then split or finish
                    if (!is_write) begin
                        if (narrow && second_byte)
                            next_rdata = {i_ext_din[7:0], rdata[7:0]};
                        else if (narrow)
                            next_rdata = {8'h00, i_ext_din[7:0]};
                        else
                            next_rdata = i_ext_din;
                    end
                    if (narrow && !second_byte) begin
                        next_second_byte = 1'b1;
                        next_wait_left   = wait_of(external_bus_timing_control, space);
                        next_unit_cnt    = 8'(emic_pkg::WAIT_UNIT_CYC - 1);
                    end else begin
                        next_state = ST_DONE;
                        next_doe   = 1'b0;
                    end
                end
                if (next_state == ST_WAIT) begin
                    xsel        = (space == emic_pkg::SPACE_XMEM);
                    next_xsel_n = !xsel;
                    next_rsel_n = !((space == emic_pkg::SPACE_RAM) ||
                        (xsel && external_bus_timing_control[emic_pkg::RAM_MERGE_BIT]));
                    next_osel_n = !((space == emic_pkg::SPACE_ROM) ||
                        (xsel && external_bus_timing_control[emic_pkg::ROM_MERGE_BIT]));
                    next_we_n   = !is_write;
                    next_oe_n   = is_write;
                end
            end
            ST_DONE: begin
                next_done  = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // stall registered so the cpu sees a clean flop output
        next_stall = (next_state != ST_IDLE);
    end

    // sequencer and pin registers; upper lines high from reset
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state       <= ST_IDLE;
            wait_left   <= 3'h0;
            unit_cnt    <= 8'h00;
            second_byte <= 1'b0;
            is_write    <= 1'b0;
            space       <= 2'h0;
            addr        <= 16'h0000;
            wdata       <= 16'h0000;
            rdata       <= 16'h0000;
            done        <= 1'b0;
            stall       <= 1'b0;
            ext_addr    <= {emic_pkg::UPPER_IDLE, {(ADDR_W-4){1'b0}}};
            xsel_n      <= 1'b1;
            rsel_n      <= 1'b1;
            osel_n      <= 1'b1;
            we_n        <= 1'b1;
            oe_n        <= 1'b1;
            doe         <= 1'b0;
            dout        <= 16'h0000;
        end else begin
            state       <= next_state;
            wait_left   <= next_wait_left;
            unit_cnt    <= next_unit_cnt;
            second_byte <= next_second_byte;
            is_write    <= next_is_write;
            space       <= next_space;
            addr        <= next_addr;
            wdata       <= next_wdata;
            rdata       <= next_rdata;
            done        <= next_done;
            stall       <= next_stall;
            ext_addr    <= next_ext_addr;
            xsel_n      <= next_xsel_n;
            rsel_n      <= next_rsel_n;
            osel_n      <= next_osel_n;
            we_n        <= next_we_n;
            oe_n        <= next_oe_n;
            doe         <= next_doe;
            dout        <= next_dout;
        end
    end

    // outputs straight from flip-flops
    assign o_cpu_stall               = stall;
    assign o_cpu_done                = done;
    assign o_cpu_rdata               = rdata;
    assign o_ext_addr                = ext_addr;
    assign o_ext_dout                = dout;
    assign o_ext_doe                 = doe;
    assign o_ext_we_n                = we_n;
    assign o_ext_oe_n                = oe_n;
    assign o_extended_space_select_n = xsel_n;
    assign o_external_ram_select_n   = rsel_n;
    assign o_external_rom_select_n   = osel_n;

endmodule // emic_ctrl
`default_nettype wire

// ==== bench/emic_checker.sv ====
// checker: select, page, upper line and stall timing assertions
`timescale 1ns/100ps
`default_nettype none
module emic_checker #(
    parameter int ADDR_W = 19                          // external address pins
) (
    input wire logic              i_clk_sys, // clock
    input wire logic              i_rst_n, // reset, active low
    input wire logic              i_sram_mode, // sram pin subset
    input wire logic [15:0]       i_reg_addr, // register address
    input wire logic [15:0]       i_reg_wdata, // register data
    input wire logic              i_reg_wr, // write strobe
    input wire logic              i_cpu_req, // request
    input wire logic [1:0]        i_cpu_space, // target space
    input wire logic [15:0]       i_cpu_addr, // cpu address
    input wire logic              o_cpu_stall, // stall
    input wire logic              o_cpu_done, // done pulse
    input wire logic [ADDR_W-1:0] o_ext_addr, // external address
    input wire logic              o_extended_space_select_n, // extended select
    input wire logic              o_external_ram_select_n,   // ram select
    input wire logic              o_external_rom_select_n    // rom select
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    logic [15:0] pg1, pg2, tmg, req_a;
    logic        up_en;
    wire         take = i_cpu_req && !o_cpu_stall;
    wire         xsel = !o_extended_space_select_n;
    wire  [15:0] pg   = (req_a[15:13] == emic_pkg::PAGE1_WIN_TOP) ? pg1 : pg2;
    // shadow of register writes and of the taken address
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pg1   <= 16'h0000;
            pg2   <= 16'h0000;
            tmg   <= 16'h0000;
            req_a <= 16'h0000;
            up_en <= 1'b0;
        end else begin
            if (i_reg_wr && i_reg_addr == emic_pkg::PAGE1_MAP_ADDR) pg1 <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == emic_pkg::PAGE2_MAP_ADDR) pg2 <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == emic_pkg::BUS_TIMING_ADDR) tmg <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == emic_pkg::UPPER_ADDR_EN_ADDR) up_en <= i_reg_wdata[3];
            if (take) req_a <= i_cpu_addr;
        end
    end
    sequence s_busy;
        (o_cpu_stall && !o_cpu_done) [*3];
    endsequence
    property p_page_full;
        xsel && !i_sram_mode |-> o_ext_addr[8:0] == pg[8:0];
    endproperty
    a_page_full: assert property (p_page_full) else $error("page bits wrong");
    property p_page_sram;
        xsel && i_sram_mode && !tmg[11] |-> o_ext_addr[8:0] == {req_a[9:6], pg[4:0]};
    endproperty
    a_page_sram: assert property (p_page_sram) else $error("sram page bits wrong");
    property p_ext_sel;
        take && i_cpu_space == 2'h0 |-> ##[1:4] xsel;
    endproperty
    a_ext_sel: assert property (p_ext_sel) else $error("extended select missing");
    property p_ram_merge;
        xsel && tmg[13] |-> !o_external_ram_select_n;
    endproperty
    a_ram_merge: assert property (p_ram_merge) else $error("ram merge missing");
    property p_rom_merge;
        xsel && tmg[12] |-> !o_external_rom_select_n;
    endproperty
    a_rom_merge: assert property (p_rom_merge) else $error("rom merge missing");
    property p_upper_off;
        o_cpu_stall && !up_en && !$past(up_en) |-> o_ext_addr[18:15] == emic_pkg::UPPER_IDLE;
    endproperty
    a_upper_off: assert property (p_upper_off) else $error("upper lines not high");
    property p_busy;
        take |=> s_busy;
    endproperty
    a_busy: assert property (p_busy) else $error("stall or done early");
    property p_done_bound;
        take |-> ##[4:120] o_cpu_done;
    endproperty
    a_done_bound: assert property (p_done_bound) else $error("access never done");
endmodule // emic_checker
bind emic_ctrl emic_checker #(.ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ==== bench/emic_mem_model.sv ====
// memory model: word array for external ram, rom and peripherals
`timescale 1ns/100ps
`default_nettype none
module emic_mem_model (
    input  wire logic        i_clk_sys, // clock
    input  wire logic [7:0]  i_addr,    // low address lines
    input  wire logic [15:0] i_dout,    // data from controller
    input  wire logic        i_we_n,    // write strobe
    input  wire logic        i_oe_n,    // output enable
    input  wire logic        i_sel_n,   // any select low
    output logic      [15:0] o_din      // data to controller
);
    logic [15:0] mem [256];
    logic [15:0] last;
    // known start pattern
    initial begin
        for (int k = 0; k < 256; k++) mem[k] = {8'h5A ^ 8'(k), 8'(k)};
        last = 16'h0000;
    end
    // store writes, remember last driven word
    always @(posedge i_clk_sys) begin
        if (!i_sel_n && !i_we_n) mem[i_addr] <= i_dout;
        if (!i_sel_n && !i_oe_n) last <= mem[i_addr];
    end
    // released bus shows the inverse of the last word
    assign o_din = (!i_sel_n && !i_oe_n) ? mem[i_addr] : ~last;
endmodule // emic_mem_model
`default_nettype wire

// ==== bench/test_emic_ctrl.sv ====
// testbench: registers, page mapping, widths, wait states, merges
`timescale 1ns/100ps
`default_nettype none
module test_emic_ctrl;
    logic        i_clk_sys, i_rst_n, i_sram_mode, i_reg_wr, i_reg_rd, i_cpu_req, i_cpu_we;
    logic [15:0] i_reg_addr, i_reg_wdata, i_cpu_addr, i_cpu_wdata, o_reg_rdata, o_cpu_rdata;
    logic [15:0] o_ext_dout, i_ext_din, rd;
    logic [18:0] o_ext_addr;
    logic [1:0]  i_cpu_space;
    logic        o_cpu_stall, o_cpu_done, o_ext_doe, we_n, oe_n, x_n, ram_n, rom_n;
    logic        ram_seen, rom_seen;
    int          num_errors, total_checks, lat;
    emic_ctrl dut (.*, .o_ext_we_n(we_n), .o_ext_oe_n(oe_n),
        .o_extended_space_select_n(x_n), .o_external_ram_select_n(ram_n),
        .o_external_rom_select_n(rom_n));
    emic_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_addr(o_ext_addr[7:0]),
        .i_dout(o_ext_dout), .i_we_n(we_n), .i_oe_n(oe_n), .i_sel_n(x_n & ram_n & rom_n),
        .o_din(i_ext_din));
    function automatic logic [15:0] pat(input logic [7:0] k);
        return {k ^ 8'h5A, k};
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // one register write cycle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge i_clk_sys);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask
    // one register read cycle, data checked the cycle after
    task automatic rdr(input logic [15:0] a, input logic [15:0] exp);
        @(posedge i_clk_sys);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1 chk(o_reg_rdata, exp);
    endtask
    // one cpu access, latency counted up to done
    task automatic acc(input logic [1:0] s, input logic we, input logic [15:0] a,
                       input logic [15:0] d);
        @(posedge i_clk_sys);
        i_cpu_req   <= 1'b1;
        i_cpu_we    <= we;
        i_cpu_space <= s;
        i_cpu_addr  <= a;
        i_cpu_wdata <= d;
        @(posedge i_clk_sys);
        i_cpu_req <= 1'b0;
        ram_seen = 1'b0;
        rom_seen = 1'b0;
        for (lat = 1; lat < 200; lat++) begin
            @(posedge i_clk_sys);
            #1;
            ram_seen |= !ram_n && !x_n;
            rom_seen |= !rom_n && !x_n;
            if (o_cpu_done === 1'b1) break;
        end
        if (lat == 200) begin
            num_errors++;
            report_and_stop();
        end
        rd = o_cpu_rdata;
    endtask
    task automatic t_regs;
        rdr(emic_pkg::PAGE1_MAP_ADDR, 16'h0000);
        rdr(emic_pkg::UPPER_ADDR_EN_ADDR, 16'h0000);
        chk({12'h000, o_ext_addr[18:15]}, 16'h000F);
        wr(emic_pkg::PAGE1_MAP_ADDR, 16'h00C3);
        wr(emic_pkg::PAGE2_MAP_ADDR, 16'h0035);
        wr(emic_pkg::UPPER_ADDR_EN_ADDR, 16'h0008);
        rdr(emic_pkg::PAGE1_MAP_ADDR, 16'h00C3);
        rdr(emic_pkg::PAGE2_MAP_ADDR, 16'h0035);
        rdr(emic_pkg::UPPER_ADDR_EN_ADDR, 16'h0008);
        wr(emic_pkg::BUS_TIMING_ADDR, 16'h3FFF);
        rdr(emic_pkg::BUS_TIMING_ADDR, 16'h3FFF);
        rdr(16'hC03C, 16'h0000);
    endtask
    // page windows, sram subset, then upper lines disabled again
    task automatic t_page;
        wr(emic_pkg::BUS_TIMING_ADDR, 16'h0000);
        acc(emic_pkg::SPACE_XMEM, 1'b0, 16'h8004, 16'h0000);
        chk(rd, pat(8'hC3));
        acc(emic_pkg::SPACE_XMEM, 1'b0, 16'hA000, 16'h0000);
        chk(rd, pat(8'h35));
        i_sram_mode <= 1'b1;
        acc(emic_pkg::SPACE_XMEM, 1'b0, 16'h8000, 16'h0000);
        chk(rd, pat(8'h03));
        i_sram_mode <= 1'b0;
        wr(emic_pkg::UPPER_ADDR_EN_ADDR, 16'h0000);
        acc(emic_pkg::SPACE_RAM, 1'b0, 16'h0040, 16'h0000);
        chk({12'h000, o_ext_addr[18:15]}, 16'h000F);
    endtask
    // data and wait-count cost at waits 0 and 7, one or two phases
    task automatic t_wait(input logic [1:0] s, input int lsb, input int wb, input int ph,
                          input logic [15:0] a, input logic [15:0] exp);
        int          l0;
        logic [15:0] t0;
        t0 = (ph == 2) ? 16'(1 << wb) : 16'h0000;
        wr(emic_pkg::BUS_TIMING_ADDR, t0);
        if (s != emic_pkg::SPACE_ROM) acc(s, 1'b1, a, exp);
        acc(s, 1'b0, a, 16'h0000);
        chk(rd, exp);
        l0 = lat;
        wr(emic_pkg::BUS_TIMING_ADDR, t0 | 16'(7 << lsb));
        acc(s, 1'b0, a, 16'h0000);
        chk(rd, exp);
        chk(16'(lat - l0), 16'(7 * emic_pkg::WAIT_UNIT_CYC * ph));
    endtask
    task automatic t_widths;
        t_wait(emic_pkg::SPACE_RAM, 0, 3, 1, 16'h0010, 16'h1234);
        t_wait(emic_pkg::SPACE_RAM, 0, 3, 2, 16'h0020, 16'hBEEF);
        t_wait(emic_pkg::SPACE_ROM, 4, 7, 1, 16'h0100, pat(8'h80));
        t_wait(emic_pkg::SPACE_ROM, 4, 7, 2, 16'h0100, 16'h0100);
        t_wait(emic_pkg::SPACE_XMEM, 8, 11, 1, 16'h8000, 16'h6666);
        t_wait(emic_pkg::SPACE_XMEM, 8, 11, 2, 16'h8000, 16'h6666);
    endtask
    // each merge bit alone during an extended access
    task automatic t_merge;
        wr(emic_pkg::BUS_TIMING_ADDR, 16'h2000);
        acc(emic_pkg::SPACE_XMEM, 1'b0, 16'h8000, 16'h0000);
        chk({ram_seen, rom_seen}, 16'h0002);
        wr(emic_pkg::BUS_TIMING_ADDR, 16'h1000);
        acc(emic_pkg::SPACE_XMEM, 1'b0, 16'h8000, 16'h0000);
        chk({ram_seen, rom_seen}, 16'h0001);
    endtask
    // free-running clock
    initial begin
        i_clk_sys = 1'b0;
        forever #10 i_clk_sys = ~i_clk_sys;
    end
    // reset, then the scenarios
    initial begin
        {i_rst_n, i_sram_mode, i_reg_wr, i_reg_rd, i_cpu_req, i_cpu_we} = 6'h00;
        {i_reg_addr, i_reg_wdata, i_cpu_addr, i_cpu_wdata} = 64'h0;
        i_cpu_space  = 2'h0;
        num_errors   = 0;
        total_checks = 0;
        repeat (5) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        t_regs();
        t_page();
        t_widths();
        t_merge();
        report_and_stop();
    end
endmodule // test_emic_ctrl
`default_nettype wire
